/* File: design/cis_pkg.sv */
`default_nettype none
package cis_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // vector table, high byte address of each pair
   localparam logic [15:0] VEC_RESET = 16'h1FFE;
   localparam logic [15:0] VEC_TRAP  = 16'h1FFC;
   localparam logic [15:0] VEC_EXT   = 16'h1FFA;
   localparam logic [15:0] VEC_TMR   = 16'h1FF8;

   ////////////////////////////////////////////////////////////////////////////////
   // entry sequence step counts
   localparam logic [3:0] CNT_PUSH_FIRST = 4'h1;
   localparam logic [3:0] CNT_PUSH_LAST  = 4'h5;
   localparam logic [3:0] CNT_MASK_SET   = 4'h6;
   localparam logic [3:0] CNT_RESOLVE    = 4'h7;
   localparam logic [3:0] CNT_VEC_HI     = 4'h8;
   localparam logic [3:0] CNT_VEC_LO     = 4'h9;
   localparam logic [3:0] CNT_END        = 4'hA;

   ////////////////////////////////////////////////////////////////////////////////
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_OPTION = 8'h00;
   localparam logic [7:0] OFS_STATE  = 8'h04;
   localparam logic [7:0] OFS_EVT    = 8'h08;
   localparam logic [7:0] OFS_EMASK  = 8'h0C;

   // option_config_reg fields and reset value
   localparam int         OPT_LEVEL   = 0;
   localparam int         OPT_KEY     = 1;
   localparam logic [1:0] OPT_RESET   = 2'h0;

   // event status bits
   localparam int EVT_RESET = 0;
   localparam int EVT_TRAP  = 1;
   localparam int EVT_EXT   = 2;
   localparam int EVT_TMR   = 3;
   localparam int EVT_RET   = 4;
   localparam int EVT_W     = 5;

   // bus answers
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {SRC_RESET, SRC_TRAP, SRC_EXT, SRC_TMR} cis_src_t;
   typedef enum logic [1:0] {ST_IDLE, ST_ENTRY, ST_RETURN} cis_state_t;

   typedef struct packed {
      logic        push;
      logic        pop;
      logic        vec_rd;
      logic [15:0] vec_addr;
   } cis_seq_t;

endpackage

`default_nettype wire

/* File: design/cis_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - hardware requests wait for instruction end
// - hardware enters only if unmasked; timer source also needs enable
// - stack registers, set mask, fetch vector
// - higher hardware vector address wins at fetch
// - any reset fetches reset vector, sets mask
// - return restores state from stack
// - soft trap ignores mask, hardware first
// - soft trap uses vector below reset
// - mask bit blocks external and timer sources, not reset pin
// - falling edge latched, latch or low requests
// - edge-only mode ignores pin level
// - key inputs behave like request pin
// - latch clears at external vector read
// - pin still low at return retriggers in level mode
// - timer flags gated by enables share vector
module cis_sequencer #(
   parameter int KEYS = 8
) (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_n_i,
   // core handshake
   input  wire logic                 instr_done_i,
   input  wire logic                 soft_trap_instr_i,
   input  wire logic                 return_from_trap_instr_i,
   input  wire logic                 restore_mask_i,
   input  wire logic                 set_mask_i,
   input  wire logic                 clr_mask_i,
   // pins
   input  wire logic                 reset_pin_n_i,
   input  wire logic                 irq_pin_n_i,
   input  wire logic [KEYS-1:0]      key_pins_n_i,
   // timer
   input  wire logic [2:0]           timer_flags_i,
   input  wire logic [2:0]           timer_ena_i,
   // sequencer outputs
   output cis_pkg::cis_seq_t         seq_o,
   output logic                      mask_bit_o,
   output logic                      busy_o,
   output logic                      irq_o,
   // axi4-lite slave
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready
);

   if (KEYS < 1 || KEYS > 8) begin : g_chk
      $error("KEYS must be 1 to 8");
   end

   localparam int SW = KEYS + 2;   // keys, request pin, reset pin

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three stages, level moves when stages two and three agree
   logic [SW-1:0] s1_q, s2_q, s3_q, filt_q;
   logic [SW-1:0] raw;

   assign raw = {reset_pin_n_i, irq_pin_n_i, key_pins_n_i};

   for (genvar i = 0; i < SW; i++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
         if (!rst_n_i) begin
            s1_q[i]   <= 1'b1;
            s2_q[i]   <= 1'b1;
            s3_q[i]   <= 1'b1;
            filt_q[i] <= 1'b1;
         end else begin
            s1_q[i] <= raw[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               filt_q[i] <= s3_q[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state
   cis_pkg::cis_state_t state_q, state_d;
   cis_pkg::cis_src_t   src_q, src_d;
   cis_pkg::cis_seq_t   seq_q, seq_d;
   logic [3:0]          cnt_q, cnt_d;
   logic                mask_q, mask_d;
   logic                trap_q, trap_d;
   logic                latch_q, latch_d;
   logic                line_q;
   logic                busy_q;
   logic [1:0]          opt_q, opt_d;
   logic [cis_pkg::EVT_W-1:0] evt_q, evt_d, emask_q, emask_d, evt_set;
   logic                irq_q, irq_d;

   logic line_n, ext_req, tmr_req, hw_req, pin_rst;

   // key inputs merged into request line
   assign line_n  = filt_q[KEYS] & (~opt_q[cis_pkg::OPT_KEY] | (&filt_q[KEYS-1:0]));
   assign ext_req = latch_q | (opt_q[cis_pkg::OPT_LEVEL] & ~line_n);
   assign tmr_req = |(timer_flags_i & timer_ena_i);
   assign hw_req  = ~mask_q & (ext_req | tmr_req);
   assign pin_rst = ~filt_q[KEYS+1];

   // vector of a source
   function automatic logic [15:0] vec_of(input cis_pkg::cis_src_t s);
      logic [15:0] v;
      case (s)
         cis_pkg::SRC_RESET: v = cis_pkg::VEC_RESET;
         cis_pkg::SRC_TRAP:  v = cis_pkg::VEC_TRAP;
         cis_pkg::SRC_EXT:   v = cis_pkg::VEC_EXT;
         default:            v = cis_pkg::VEC_TMR;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb begin
      state_d = state_q;
      src_d   = src_q;
      cnt_d   = cnt_q;
      mask_d  = mask_q;
      seq_d   = '0;
      evt_set = '0;
      // soft trap held until served
      trap_d  = trap_q | soft_trap_instr_i;
      // catch falling edge, set wins over clear
      latch_d = latch_q;
      if (state_q == cis_pkg::ST_ENTRY && cnt_q == cis_pkg::CNT_VEC_LO
          && src_q == cis_pkg::SRC_EXT) begin
         latch_d = 1'b0;
      end
      if (line_q & ~line_n) begin
         latch_d = 1'b1;
      end
      case (state_q)
         cis_pkg::ST_IDLE: begin
            if (set_mask_i) begin
               mask_d = 1'b1;
            end else if (clr_mask_i) begin
               mask_d = 1'b0;
            end
            if (instr_done_i && hw_req) begin
               state_d = cis_pkg::ST_ENTRY;
               cnt_d   = cis_pkg::CNT_PUSH_FIRST;
               src_d   = ext_req ? cis_pkg::SRC_EXT : cis_pkg::SRC_TMR;
            end else if (trap_q) begin
               state_d = cis_pkg::ST_ENTRY;
               cnt_d   = cis_pkg::CNT_PUSH_FIRST;
               src_d   = cis_pkg::SRC_TRAP;
               trap_d  = soft_trap_instr_i;
            end else if (return_from_trap_instr_i) begin
               state_d = cis_pkg::ST_RETURN;
               cnt_d   = cis_pkg::CNT_PUSH_FIRST;
            end
         end
         cis_pkg::ST_ENTRY: begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q <= cis_pkg::CNT_PUSH_LAST) begin
               seq_d.push = 1'b1;
            end
            if (cnt_q == cis_pkg::CNT_MASK_SET) begin
               mask_d = 1'b1;
            end
            if (cnt_q == cis_pkg::CNT_RESOLVE && src_q != cis_pkg::SRC_RESET
                && src_q != cis_pkg::SRC_TRAP) begin
               if (ext_req) begin
                  src_d = cis_pkg::SRC_EXT;
               end else if (tmr_req) begin
                  src_d = cis_pkg::SRC_TMR;
               end
            end
            if (cnt_q == cis_pkg::CNT_VEC_HI) begin
               seq_d.vec_rd   = 1'b1;
               seq_d.vec_addr = vec_of(src_q);
            end
            if (cnt_q == cis_pkg::CNT_VEC_LO) begin
               seq_d.vec_rd   = 1'b1;
               seq_d.vec_addr = vec_of(src_q) + 16'h0001;
            end
            if (cnt_q == cis_pkg::CNT_END) begin
               state_d = cis_pkg::ST_IDLE;
               cnt_d   = '0;
               case (src_q)
                  cis_pkg::SRC_RESET: evt_set[cis_pkg::EVT_RESET] = 1'b1;
                  cis_pkg::SRC_TRAP:  evt_set[cis_pkg::EVT_TRAP]  = 1'b1;
                  cis_pkg::SRC_EXT:   evt_set[cis_pkg::EVT_EXT]   = 1'b1;
                  default:            evt_set[cis_pkg::EVT_TMR]   = 1'b1;
               endcase
            end
         end
         cis_pkg::ST_RETURN: begin
            seq_d.pop = 1'b1;
            cnt_d     = cnt_q + 4'h1;
            if (cnt_q == cis_pkg::CNT_PUSH_FIRST) begin
               mask_d = restore_mask_i;
            end
            if (cnt_q == cis_pkg::CNT_PUSH_LAST) begin
               state_d = cis_pkg::ST_IDLE;
               cnt_d   = '0;
               evt_set[cis_pkg::EVT_RET] = 1'b1;
            end
         end
         default: begin
            state_d = cis_pkg::ST_IDLE;
            cnt_d   = '0;
         end
      endcase
      // reset pin restarts at reset vector
      if (pin_rst) begin
         state_d = cis_pkg::ST_ENTRY;
         cnt_d   = cis_pkg::CNT_MASK_SET;
         src_d   = cis_pkg::SRC_RESET;
         mask_d  = 1'b1;
         seq_d   = '0;
         trap_d  = 1'b0;
         latch_d = 1'b0;
      end
   end

   // sequencer registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_q <= cis_pkg::ST_ENTRY;
         cnt_q   <= cis_pkg::CNT_MASK_SET;
         src_q   <= cis_pkg::SRC_RESET;
         mask_q  <= 1'b1;
         seq_q   <= '0;
         trap_q  <= 1'b0;
         latch_q <= 1'b0;
         line_q  <= 1'b1;
         busy_q  <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         src_q   <= src_d;
         mask_q  <= mask_d;
         seq_q   <= seq_d;
         trap_q  <= trap_d;
         latch_q <= latch_d;
         line_q  <= line_n;
         busy_q  <= (state_d != cis_pkg::ST_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic        wstrb0_q, wstrb0_d;
   logic        awready_q, awready_d, wready_q, wready_d;
   logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic        do_wr;

   // bus next state and register writes
   always_comb begin
      aw_got_d = aw_got_q | (s_axi_awvalid & awready_q);
      w_got_d  = w_got_q | (s_axi_wvalid & wready_q);
      awaddr_d = (s_axi_awvalid & awready_q) ? s_axi_awaddr : awaddr_q;
      wdata_d  = (s_axi_wvalid & wready_q) ? s_axi_wdata : wdata_q;
      wstrb0_d = (s_axi_wvalid & wready_q) ? s_axi_wstrb[0] : wstrb0_q;
      bvalid_d = bvalid_q & ~s_axi_bready;
      bresp_d  = bresp_q;
      opt_d    = opt_q;
      emask_d  = emask_q;
      evt_d    = evt_q;
      do_wr    = aw_got_q & w_got_q & ~bvalid_q;
      if (do_wr) begin
         aw_got_d = 1'b0;
         w_got_d  = 1'b0;
         bvalid_d = 1'b1;
         bresp_d  = cis_pkg::RESP_OKAY;
         case (awaddr_q)
            cis_pkg::OFS_OPTION: if (wstrb0_q) opt_d = wdata_q[1:0];
            cis_pkg::OFS_STATE:  ;
            cis_pkg::OFS_EVT:    if (wstrb0_q) evt_d = evt_q & ~wdata_q[cis_pkg::EVT_W-1:0];
            cis_pkg::OFS_EMASK:  if (wstrb0_q) emask_d = wdata_q[cis_pkg::EVT_W-1:0];
            default:             bresp_d = cis_pkg::RESP_SLVERR;
         endcase
      end
      // events set over a same-cycle clear
      evt_d     = evt_d | evt_set;
      awready_d = ~aw_got_d & ~bvalid_d;
      wready_d  = ~w_got_d & ~bvalid_d;
      irq_d     = |(evt_d & emask_d);
      // read path
      rvalid_d  = rvalid_q & ~s_axi_rready;
      rdata_d   = rdata_q;
      rresp_d   = rresp_q;
      if (s_axi_arvalid & arready_q) begin
         rvalid_d = 1'b1;
         rresp_d  = cis_pkg::RESP_OKAY;
         rdata_d  = '0;
         case (s_axi_araddr)
            cis_pkg::OFS_OPTION: rdata_d[1:0] = opt_q;
            cis_pkg::OFS_STATE:  rdata_d[9:0] = {src_q, 3'h0, busy_q, tmr_req,
                                                 ext_req, latch_q, mask_q};
            cis_pkg::OFS_EVT:    rdata_d[cis_pkg::EVT_W-1:0] = evt_q;
            cis_pkg::OFS_EMASK:  rdata_d[cis_pkg::EVT_W-1:0] = emask_q;
            default:             rresp_d = cis_pkg::RESP_SLVERR;
         endcase
      end
      arready_d = ~rvalid_d;
   end

   // bus registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb0_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= cis_pkg::RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rresp_q   <= cis_pkg::RESP_OKAY;
         rdata_q   <= '0;
         opt_q     <= cis_pkg::OPT_RESET;
         evt_q     <= '0;
         emask_q   <= '0;
         irq_q     <= 1'b0;
      end else begin
         aw_got_q  <= aw_got_d;
         w_got_q   <= w_got_d;
         awaddr_q  <= awaddr_d;
         wdata_q   <= wdata_d;
         wstrb0_q  <= wstrb0_d;
         awready_q <= awready_d;
         wready_q  <= wready_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         arready_q <= arready_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         opt_q     <= opt_d;
         evt_q     <= evt_d;
         emask_q   <= emask_d;
         irq_q     <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign seq_o         = seq_q;
   assign mask_bit_o    = mask_q;
   assign busy_o        = busy_q;
   assign irq_o         = irq_q;
   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

endmodule

`default_nettype wire

/* File: tb/cis_sequencer_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// watches the trap sequencer outputs
module cis_sequencer_properties (
   input wire logic              ref_clk_i,
   input wire logic              rst_n_i,
   input wire cis_pkg::cis_seq_t seq_o,
   input wire logic              mask_bit_o,
   input wire logic              busy_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_vec_masked: assert property (seq_o.vec_rd |-> mask_bit_o)
      else $error("vector fetched with mask clear");
   chk_vec_pair: assert property (seq_o.vec_rd && !seq_o.vec_addr[0] |=>
      seq_o.vec_rd && seq_o.vec_addr == $past(seq_o.vec_addr) + 16'h0001)
      else $error("vector low byte does not follow high byte");
   chk_vec_range: assert property (seq_o.vec_rd |-> seq_o.vec_addr[15:3] == 13'h03FF)
      else $error("vector address outside the table");
   chk_push_burst: assert property ($rose(seq_o.push) |-> seq_o.push [*5] ##1 !seq_o.push)
      else $error("stacking is not five pushes");
   chk_pop_burst: assert property ($rose(seq_o.pop) |-> seq_o.pop [*5] ##1 !seq_o.pop)
      else $error("unstacking is not five pops");
   chk_push_to_vec: assert property ($rose(seq_o.push) |-> ##[6:10] seq_o.vec_rd)
      else $error("no vector fetch after stacking");
   chk_reset_vec: assert property ($rose(rst_n_i) |->
      ##[1:5] (seq_o.vec_rd && seq_o.vec_addr == cis_pkg::VEC_RESET))
      else $error("no start vector fetch after reset");
   chk_vec_to_idle: assert property (seq_o.vec_rd && seq_o.vec_addr[0] |-> ##[1:2] !busy_o)
      else $error("sequencer stays busy after vector fetch");
endmodule

bind cis_sequencer cis_sequencer_properties cis_sequencer_properties_inst (
   .ref_clk_i  (ref_clk_i),
   .rst_n_i    (rst_n_i),
   .seq_o      (seq_o),
   .mask_bit_o (mask_bit_o),
   .busy_o     (busy_o)
);
`default_nettype wire

/* File: tb/cis_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
// core stand-in: reports instruction ends, counts stack bytes
module cis_core_model (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              run_i,
   input  wire logic              busy_i,
   input  wire cis_pkg::cis_seq_t seq_i,
   output logic                  instr_done_o,
   output logic [3:0]            depth_o
);
   logic [1:0] cyc_q, cyc_d;
   logic [3:0] depth_q, depth_d;
   // instruction ends, stack depth
   // core stalls while sequencing, so instructions end only when idle
   always_comb begin
      cyc_d   = (run_i && !busy_i) ? cyc_q + 2'h1 : 2'h0;
      depth_d = depth_q + {3'h0, seq_i.push} - {3'h0, seq_i.pop};
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         cyc_q   <= 2'h0;
         depth_q <= 4'h0;
      end else begin
         cyc_q   <= cyc_d;
         depth_q <= depth_d;
      end
   end
   // one instruction ends every fourth cycle
   assign instr_done_o = run_i && !busy_i && (cyc_q == 2'h3);
   assign depth_o      = depth_q;
endmodule
`default_nettype wire

/* File: tb/cis_sequencer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module cis_sequencer_test;
   logic              ref_clk_i = 1'b0, rst_n_i = 1'b0, run = 1'b0;
   logic [3:0]        core_ctl  = 4'h0; // soft trap, return, set mask, clear mask
   logic              rpin_n    = 1'b1, ipin_n = 1'b1, rmask = 1'b0;
   logic [7:0]        keys_n    = 8'hFF;
   logic [2:0]        tflag     = 3'h0, tena = 3'h0;
   logic [7:0]        awaddr    = 8'h00, araddr = 8'h00;
   logic [31:0]       wdata     = 32'h0000_0000;
   logic              awvalid   = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic              arvalid   = 1'b0, rready = 1'b0;
   logic              awready, wready, bvalid, arready, rvalid, idone, mask, busy, irq;
   logic [1:0]        bresp, rresp;
   logic [31:0]       rdata;
   logic [3:0]        depth;
   cis_pkg::cis_seq_t seq;
   logic [15:0]       vq[$];
   int                mismatches = 0, checks_done = 0;

   // 200 MHz clock
   always #2.5 ref_clk_i = ~ref_clk_i;

   cis_sequencer #(.KEYS(8)) cis_sequencer_inst (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_done_i(idone),
      .soft_trap_instr_i(core_ctl[0]), .return_from_trap_instr_i(core_ctl[1]),
      .restore_mask_i(rmask), .set_mask_i(core_ctl[2]), .clr_mask_i(core_ctl[3]),
      .reset_pin_n_i(rpin_n), .irq_pin_n_i(ipin_n), .key_pins_n_i(keys_n),
      .timer_flags_i(tflag), .timer_ena_i(tena), .seq_o(seq), .mask_bit_o(mask),
      .busy_o(busy), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   cis_core_model cis_core_model_inst (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .run_i(run), .busy_i(busy),
      .seq_i(seq), .instr_done_o(idone), .depth_o(depth));

   // collect every vector byte fetched
   always @(posedge ref_clk_i) if (seq.vec_rd === 1'b1) vq.push_back(seq.vec_addr);

   ////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   // one-cycle core strobes, optional two-cycle request pin dip
   // a single-cycle dip would be filtered out by the pin synchroniser
   task automatic pulse(input logic [3:0] m, input bit p);
      tick(1);
      core_ctl <= m;
      if (p) ipin_n <= 1'b0;
      tick(1);
      core_ctl <= 4'h0;
      tick(1);
      if (p) ipin_n <= 1'b1;
   endtask
   // one bus transfer; read data compared under mask m
   task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] er);
      tick(1);
      awaddr  <= a;
      araddr  <= a;
      wdata   <= d;
      awvalid <= w;
      wvalid  <= w;
      bready  <= w;
      arvalid <= !w;
      rready  <= !w;
      // wait for the answer; only the watchdog ends a hung transfer
      while (!(bvalid === 1'b1 || rvalid === 1'b1)) begin
         tick(1);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      chk(32'(w ? bresp : rresp), 32'(er));
      if (!w) chk(rdata & m, d);
      bready <= 1'b0;
      rready <= 1'b0;
   endtask
   // expect one vector pair, or none at all
   task automatic expv(input logic [15:0] base, input bit none);
      int n;
      n = 0;
      while (vq.size() < 2 && n < 60) begin
         tick(1);
         n++;
      end
      chk(32'(vq.size()), none ? 32'h0 : 32'h2);
      if (!none) chk({vq[0], vq[1]}, {base, base + 16'h0001});
      tick(3);
      vq.delete();
   endtask
   task automatic ret_isr();
      pulse(4'h2, 1'b0);
      tick(12);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // watchdog against a hung sequence
   initial begin
      tick(20000);
      mismatches++;
      end_sim();
   end

   initial begin
      tick(20);
      rst_n_i <= 1'b1;
      run     <= 1'b1;
      expv(cis_pkg::VEC_RESET, 1'b0);
      chk(32'(mask), 32'h1);
      axi(1'b0, cis_pkg::OFS_OPTION, 32'h0, 32'h3, cis_pkg::RESP_OKAY);
      $display("test reset done");
      pulse(4'h0, 1'b1);
      expv(16'h0, 1'b1);
      axi(1'b0, cis_pkg::OFS_STATE, 32'h2, 32'h2, cis_pkg::RESP_OKAY);
      tflag <= 3'h7;
      tena  <= 3'h1;
      pulse(4'h8, 1'b0);
      expv(cis_pkg::VEC_EXT, 1'b0);
      chk({28'h0, depth}, 32'h5);
      chk(32'(mask), 32'h1);
      axi(1'b0, cis_pkg::OFS_STATE, 32'h0, 32'h2, cis_pkg::RESP_OKAY);
      ret_isr();
      expv(cis_pkg::VEC_TMR, 1'b0);
      tena <= 3'h0;
      ret_isr();
      chk({27'h0, depth, mask}, 32'h0);
      expv(16'h0, 1'b1);
      for (int i = 1; i < 3; i++) begin
         tena <= 3'h1 << i;
         expv(cis_pkg::VEC_TMR, 1'b0);
         tena <= 3'h0;
         ret_isr();
      end
      tflag <= 3'h0;
      $display("test priority done");
      axi(1'b1, cis_pkg::OFS_OPTION, 32'h1, 32'h0, cis_pkg::RESP_OKAY);
      ipin_n <= 1'b0;
      expv(cis_pkg::VEC_EXT, 1'b0);
      ret_isr();
      expv(cis_pkg::VEC_EXT, 1'b0);
      ipin_n <= 1'b1;
      ret_isr();
      expv(16'h0, 1'b1);
      axi(1'b1, cis_pkg::OFS_OPTION, 32'h0, 32'h0, cis_pkg::RESP_OKAY);
      ipin_n <= 1'b0;
      expv(cis_pkg::VEC_EXT, 1'b0);
      ret_isr();
      expv(16'h0, 1'b1);
      ipin_n <= 1'b1;
      axi(1'b1, cis_pkg::OFS_OPTION, 32'h2, 32'h0, cis_pkg::RESP_OKAY);
      keys_n <= 8'hF7;
      expv(cis_pkg::VEC_EXT, 1'b0);
      keys_n <= 8'hFF;
      ret_isr();
      expv(16'h0, 1'b1);
      $display("test pin modes done");
      run <= 1'b0;
      pulse(4'h0, 1'b1);
      expv(16'h0, 1'b1);
      run <= 1'b1;
      expv(cis_pkg::VEC_EXT, 1'b0);
      ret_isr();
      pulse(4'h4, 1'b1);
      expv(16'h0, 1'b1);
      pulse(4'h1, 1'b0);
      expv(cis_pkg::VEC_TRAP, 1'b0);
      rmask <= 1'b1;
      ret_isr();
      chk(32'(mask), 32'h1);
      expv(16'h0, 1'b1);
      rmask <= 1'b0;
      pulse(4'h8, 1'b0);
      expv(cis_pkg::VEC_EXT, 1'b0);
      ret_isr();
      $display("test soft trap done");
      axi(1'b0, cis_pkg::OFS_EVT, 32'h1F, 32'h1F, cis_pkg::RESP_OKAY);
      axi(1'b1, cis_pkg::OFS_EMASK, 32'h0, 32'h0, cis_pkg::RESP_OKAY);
      tick(2);
      chk(32'(irq), 32'h0);
      axi(1'b1, cis_pkg::OFS_EMASK, 32'h4, 32'h0, cis_pkg::RESP_OKAY);
      tick(2);
      chk(32'(irq), 32'h1);
      axi(1'b1, cis_pkg::OFS_EVT, 32'h4, 32'h0, cis_pkg::RESP_OKAY);
      tick(2);
      chk(32'(irq), 32'h0);
      axi(1'b0, cis_pkg::OFS_EVT, 32'h1B, 32'h1F, cis_pkg::RESP_OKAY);
      axi(1'b1, cis_pkg::OFS_STATE, 32'h0, 32'h0, cis_pkg::RESP_OKAY);
      axi(1'b1, 8'h40, 32'h1, 32'h0, cis_pkg::RESP_SLVERR);
      axi(1'b0, 8'h40, 32'h0, 32'hFFFF_FFFF, cis_pkg::RESP_SLVERR);
      $display("test registers done");
      rpin_n <= 1'b0;
      tick(2);
      rpin_n <= 1'b1;
      expv(cis_pkg::VEC_RESET, 1'b0);
      chk(32'(mask), 32'h1);
      $display("test reset pin done");
      end_sim();
   end
endmodule
`default_nettype wire
